//--- design/imd_cfg.svh
// Purpose: Constants of the command message decoder
// Assumes: APB byte addresses, 32-bit data
// Notes:   Definitions only
`ifndef IMD_CFG_SVH
`define IMD_CFG_SVH

// --------------------
// Register byte offsets
// --------------------
`define IMD_REG_MSG_DATA   8'h00
`define IMD_REG_MSG_CTRL   8'h04
`define IMD_REG_STATUS     8'h08
`define IMD_REG_TX_PORT    8'h0c
`define IMD_REG_RX_PORT    8'h10
`define IMD_REG_DEV_CFG    8'h14
`define IMD_REG_GRP_SEL    8'h18
`define IMD_REG_GRP_CFG0   8'h1c
`define IMD_REG_GRP_CFG1   8'h20

// --------------------
// Control bit positions
// --------------------
`define IMD_CTRL_EXEC      0
`define IMD_CTRL_ABORT     1

// --------------------
// Message bytes
// --------------------
`define IMD_BYTE_HANDLER   0
`define IMD_BYTE_CODE      1
`define IMD_BYTE_P1        2
`define IMD_REPLY_OFFSET   8'h80
`define IMD_ALARM_HANDLER  8'hff

// --------------------
// Command codes and message lengths
// --------------------
`define IMD_CMD_DEV        8'h01
`define IMD_CMD_PORT       8'h03
`define IMD_CMD_LOOP       8'h04
`define IMD_CMD_GPAR       8'h05
`define IMD_CMD_GPORT      8'h06
`define IMD_CMD_GMODE      8'h07
`define IMD_LEN_DEV        5'h0a
`define IMD_LEN_PORT       5'h0a
`define IMD_LEN_LOOP       5'h03
`define IMD_LEN_GPAR       5'h0b
`define IMD_LEN_GPORT      5'h05
`define IMD_LEN_GMODE      5'h06

// --------------------
// Acknowledge codes and limits
// --------------------
`define IMD_ACK_OK         8'h00
`define IMD_ACK_BAD        8'h01
`define IMD_ACK_NOT_CFG    8'h02
`define IMD_GRP_MAX        8'h03
`define IMD_LINK_MIN       8'h01
`define IMD_LINK_MAX       8'h04
`define IMD_DELAY_MAX      16'h0400
`define IMD_LOOP_MAX       8'h03
`define IMD_SYM_MAX        8'h02
`define IMD_M_BASE         9'h020

// --------------------
// Reset values and timing counts
// --------------------
`define IMD_RST_LCD_THR    8'h68
`define IMD_RST_PORT       5'h1f
`define IMD_RST_STUFF      1'h1
`define IMD_RST_ADV        1'h1
`define IMD_STUFF_LAST     11'h7ff

`endif

//--- design/imd_decoder.sv
// Purpose: Command message decoder with APB register access
// Assumes: cell_tick, ocd_anomaly and link counts come from pclk logic
// Notes:   One reply or alarm message is held at a time
//
// Summary of operation
// - Reply handler is command handler plus 128
// - Alarm message: FFH, link id, alarm type
// - Codes 01H..22H, host sends only listed
// - Default device parameters until setup arrives
// - Loss defect after anomaly lasts threshold cells
// - Ack 0 ok, 1 bad length
// - Bytes 1-4 form transmit mask, MSB first
// - Bytes 5-8 form receive mask likewise
// - Loopback byte 0..3, others mean 0
// - Second group byte is logical group id
// - Frame length code 0..3 gives 32..256
// - Backward compatibility byte 1 allows v1.0
// - Operational only with enough transmit links
// - Receive minimum, symmetric mode uses transmit
// - Group ports 0..30, ack 2 if unconfigured
// - Symmetry mode above 2 treated as 0
// - Stuff mode byte, default common clock
// - Stuff advance bit: 1 or 4 frames
// - Common clock stuff after every 2048 cells
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "imd_cfg.svh"

module imd_decoder
    import imd_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Link status from the cell engine
    input  wire logic [3:0]        cell_tick,
    input  wire logic [3:0]        ocd_anomaly,
    input  wire logic [3:0][1:0]   link_group,
    input  wire logic [3:0][2:0]   tx_link_cnt,
    input  wire logic [3:0][2:0]   rx_link_cnt,
    // Device configuration
    output logic [31:0]            tx_port_en,
    output logic [31:0]            rx_port_en,
    output logic [1:0]             loop_mode,
    output logic [3:0]             lcd_defect,
    output logic [3:0]             stuff_insert,
    // Group configuration
    output logic [3:0][7:0]        grp_logical_id,
    output logic [3:0][8:0]        grp_tx_frame_len,
    output logic [3:0][3:0]        grp_rx_m_mask,
    output logic [3:0]             grp_compat_v10,
    output logic [3:0][4:0]        grp_tx_port,
    output logic [3:0][4:0]        grp_rx_port,
    output logic [3:0][1:0]        grp_sym_mode,
    output logic [3:0]             grp_stuff_adv4,
    output logic [3:0]             grp_operational
);

    // Alarm type index reported for delineation loss; arbitrary value
    parameter logic [7:0] ALARM_LCD = 8'h01;

    // ----------------------------------------
    // Reset image
    // ----------------------------------------
    function automatic imd_state_t reset_state();
        imd_state_t r;
        r = '0;
        r.bus_st = IMD_BUS_IDLE;
        r.lcd_thr = `IMD_RST_LCD_THR;
        for (int g = 0; g < 4; g++) begin
            r.grp[g].tx_port = `IMD_RST_PORT;
            r.grp[g].rx_port = `IMD_RST_PORT;
            r.grp[g].stuff_common = `IMD_RST_STUFF;
            r.grp[g].stuff_adv4 = `IMD_RST_ADV;
            r.tx_frame_len[g] = `IMD_M_BASE;
        end
        return r;
    endfunction

    localparam imd_state_t RST = reset_state();

    imd_state_t q;
    imd_state_t d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [7:0]  ack;
        logic [7:0]  code;
        logic [7:0]  gid_b;
        logic [1:0]  gid;
        logic [15:0] dly;
        logic [2:0]  rx_eff;
        logic        exec;
        logic [3:0]  pend_set;
        logic [3:0]  pend_clr;
        d = q;
        ack = `IMD_ACK_OK;
        code = q.cmd_buf[`IMD_BYTE_CODE];
        gid_b = q.cmd_buf[`IMD_BYTE_P1];
        gid = gid_b[1:0];
        dly = {q.cmd_buf[`IMD_BYTE_P1+4], q.cmd_buf[`IMD_BYTE_P1+5]};
        rx_eff = '0;
        exec = 1'b0;
        pend_set = '0;
        pend_clr = '0;
        d.stuff_pulse = '0;

        // Bus: no wait state, data settled in the setup cycle
        case (q.bus_st)
            IMD_BUS_IDLE: begin
                d.pready = 1'b0;
                d.pslverr = 1'b0;
                if (psel && !penable) begin
                    d.pready = 1'b1;
                    d.bus_st = IMD_BUS_ACK;
                    d.prdata = '0;
                    case (paddr)
                        `IMD_REG_MSG_DATA:
                            d.prdata = {24'h0, q.out_buf[q.out_idx]};
                        `IMD_REG_MSG_CTRL: d.prdata = '0;
                        `IMD_REG_STATUS:
                            d.prdata = {8'h0, q.grp_oper, q.lcd_defect, 7'h0, q.cmd_len,
                                        2'h0, q.dev_setup_done, q.out_idx != q.out_len};
                        `IMD_REG_TX_PORT: d.prdata = q.tx_port_en;
                        `IMD_REG_RX_PORT: d.prdata = q.rx_port_en;
                        `IMD_REG_DEV_CFG: d.prdata = {22'h0, q.lcd_thr, q.loop_mode};
                        `IMD_REG_GRP_SEL: d.prdata = {30'h0, q.grp_sel};
                        `IMD_REG_GRP_CFG0:
                            d.prdata = q.grp[q.grp_sel][46:15];
                        `IMD_REG_GRP_CFG1:
                            d.prdata = {17'h0, q.grp[q.grp_sel][14:0]};
                        default: d.pslverr = 1'b1;
                    endcase
                end
            end
            IMD_BUS_ACK: begin
                d.pready = 1'b0;
                d.pslverr = 1'b0;
                d.bus_st = IMD_BUS_IDLE;
                if (psel && penable && !q.pslverr) begin
                    if (pwrite) begin
                        case (paddr)
                            `IMD_REG_MSG_DATA: begin
                                if (q.cmd_len != 5'h10) begin
                                    d.cmd_buf[q.cmd_len[3:0]] = pwdata[7:0];
                                    d.cmd_len = q.cmd_len + 5'h01;
                                end
                            end
                            `IMD_REG_MSG_CTRL: begin
                                exec = pwdata[`IMD_CTRL_EXEC];
                                if (pwdata[`IMD_CTRL_ABORT])
                                    d.cmd_len = '0;
                            end
                            `IMD_REG_GRP_SEL: d.grp_sel = pwdata[1:0];
                            default: ;
                        endcase
                    end else if (paddr == `IMD_REG_MSG_DATA && q.out_idx != q.out_len) begin
                        d.out_idx = q.out_idx + 2'h1;
                    end
                end
            end
            default: begin
                d.bus_st = IMD_BUS_IDLE;
                d.pready = 1'b0;
                d.pslverr = 1'b0;
            end
        endcase

        // Command execution
        if (exec) begin
            case (code)
                `IMD_CMD_DEV: begin
                    if (q.cmd_len != `IMD_LEN_DEV)
                        ack = `IMD_ACK_BAD;
                    else begin
                        d.lcd_thr = q.cmd_buf[`IMD_BYTE_P1+7];
                        d.dev_setup_done = 1'b1;
                    end
                end
                `IMD_CMD_PORT: begin
                    if (q.cmd_len != `IMD_LEN_PORT)
                        ack = `IMD_ACK_BAD;
                    else begin
                        d.tx_port_en = {q.cmd_buf[`IMD_BYTE_P1], q.cmd_buf[`IMD_BYTE_P1+1],
                            q.cmd_buf[`IMD_BYTE_P1+2], q.cmd_buf[`IMD_BYTE_P1+3]};
                        d.rx_port_en = {q.cmd_buf[`IMD_BYTE_P1+4], q.cmd_buf[`IMD_BYTE_P1+5],
                            q.cmd_buf[`IMD_BYTE_P1+6], q.cmd_buf[`IMD_BYTE_P1+7]};
                    end
                end
                `IMD_CMD_LOOP: begin
                    if (q.cmd_len != `IMD_LEN_LOOP)
                        ack = `IMD_ACK_BAD;
                    else if (gid_b > `IMD_LOOP_MAX)
                        d.loop_mode = '0;
                    else
                        d.loop_mode = gid_b[1:0];
                end
                `IMD_CMD_GPAR: begin
                    if (q.cmd_len != `IMD_LEN_GPAR || gid_b > `IMD_GRP_MAX
                        || q.cmd_buf[`IMD_BYTE_P1+2] > `IMD_LOOP_MAX
                        || dly > `IMD_DELAY_MAX
                        || q.cmd_buf[`IMD_BYTE_P1+7] < `IMD_LINK_MIN
                        || q.cmd_buf[`IMD_BYTE_P1+7] > `IMD_LINK_MAX
                        || q.cmd_buf[`IMD_BYTE_P1+8] < `IMD_LINK_MIN
                        || q.cmd_buf[`IMD_BYTE_P1+8] > `IMD_LINK_MAX)
                        ack = `IMD_ACK_BAD;
                    else begin
                        d.grp[gid].logical_id = q.cmd_buf[`IMD_BYTE_P1+1];
                        d.grp[gid].tx_m_code = q.cmd_buf[`IMD_BYTE_P1+2][1:0];
                        d.grp[gid].rx_m_mask = q.cmd_buf[`IMD_BYTE_P1+3][3:0];
                        d.grp[gid].max_delay = dly[10:0];
                        d.grp[gid].compat_v10 =
                            (q.cmd_buf[`IMD_BYTE_P1+6] == 8'h01);
                        d.grp[gid].tx_min = q.cmd_buf[`IMD_BYTE_P1+7][2:0];
                        d.grp[gid].rx_min = q.cmd_buf[`IMD_BYTE_P1+8][2:0];
                        d.grp[gid].configured = 1'b1;
                    end
                end
                `IMD_CMD_GPORT: begin
                    if (q.cmd_len != `IMD_LEN_GPORT || gid_b > `IMD_GRP_MAX)
                        ack = `IMD_ACK_BAD;
                    else if (!q.grp[gid].configured)
                        ack = `IMD_ACK_NOT_CFG;
                    else begin
                        d.grp[gid].tx_port = q.cmd_buf[`IMD_BYTE_P1+1][4:0];
                        d.grp[gid].rx_port = q.cmd_buf[`IMD_BYTE_P1+2][4:0];
                    end
                end
                `IMD_CMD_GMODE: begin
                    if (q.cmd_len != `IMD_LEN_GMODE || gid_b > `IMD_GRP_MAX)
                        ack = `IMD_ACK_BAD;
                    else if (!q.grp[gid].configured)
                        ack = `IMD_ACK_NOT_CFG;
                    else begin
                        if (q.cmd_buf[`IMD_BYTE_P1+1] > `IMD_SYM_MAX)
                            d.grp[gid].sym_mode = '0;
                        else
                            d.grp[gid].sym_mode = q.cmd_buf[`IMD_BYTE_P1+1][1:0];
                        d.grp[gid].stuff_common = q.cmd_buf[`IMD_BYTE_P1+2][0];
                        d.grp[gid].stuff_adv4 = q.cmd_buf[`IMD_BYTE_P1+3][0];
                    end
                end
                // Other codes live elsewhere; refuse
                default: ack = `IMD_ACK_BAD;
            endcase
            d.out_buf[0] = q.cmd_buf[`IMD_BYTE_HANDLER] + `IMD_REPLY_OFFSET;
            d.out_buf[1] = ack;
            d.out_len = 2'h2;
            d.out_idx = '0;
            d.cmd_len = '0;
        end

        // Delineation loss per link
        for (int l = 0; l < 4; l++) begin
            if (!ocd_anomaly[l]) begin
                d.lcd_cnt[l] = '0;
                d.lcd_defect[l] = 1'b0;
            end else if (q.lcd_cnt[l] >= q.lcd_thr) begin
                d.lcd_defect[l] = 1'b1;
                pend_set[l] = !q.lcd_defect[l];
            end else if (cell_tick[l]) begin
                d.lcd_cnt[l] = q.lcd_cnt[l] + 8'h01;
            end
        end

        // Alarm waits until the reply slot drains; reply has priority
        if (!exec && q.out_idx == q.out_len && |q.alarm_pend) begin
            for (int l = 3; l >= 0; l--) begin
                if (q.alarm_pend[l]) begin
                    pend_clr = 4'h0;
                    pend_clr[l] = 1'b1;
                    d.out_buf[1] = 8'(l);
                end
            end
            d.out_buf[0] = `IMD_ALARM_HANDLER;
            d.out_buf[2] = ALARM_LCD;
            d.out_len = 2'h3;
            d.out_idx = '0;
        end
        d.alarm_pend = (q.alarm_pend & ~pend_clr) | pend_set;

        // Common clock stuffing, cell counter per link
        for (int l = 0; l < 4; l++) begin
            if (cell_tick[l]) begin
                d.stuff_cnt[l] = q.stuff_cnt[l] + 11'h001;
                if (q.stuff_cnt[l] == `IMD_STUFF_LAST)
                    d.stuff_pulse[l] = q.grp[link_group[l]].stuff_common;
            end
        end

        // Group readiness and frame length
        for (int g = 0; g < 4; g++) begin
            if (q.grp[g].sym_mode == 2'h0 && q.grp[g].rx_min != q.grp[g].tx_min)
                rx_eff = q.grp[g].tx_min;
            else
                rx_eff = q.grp[g].rx_min;
            d.grp_oper[g] = q.grp[g].configured
                && tx_link_cnt[g] >= q.grp[g].tx_min
                && rx_link_cnt[g] >= rx_eff;
            d.tx_frame_len[g] = `IMD_M_BASE << q.grp[g].tx_m_code;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            q <= RST;
        else
            q <= d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        prdata = q.prdata;
        pready = q.pready;
        pslverr = q.pslverr;
        tx_port_en = q.tx_port_en;
        rx_port_en = q.rx_port_en;
        loop_mode = q.loop_mode;
        lcd_defect = q.lcd_defect;
        stuff_insert = q.stuff_pulse;
        grp_tx_frame_len = q.tx_frame_len;
        grp_operational = q.grp_oper;
        for (int g = 0; g < 4; g++) begin
            grp_logical_id[g] = q.grp[g].logical_id;
            grp_rx_m_mask[g] = q.grp[g].rx_m_mask;
            grp_compat_v10[g] = q.grp[g].compat_v10;
            grp_tx_port[g] = q.grp[g].tx_port;
            grp_rx_port[g] = q.grp[g].rx_port;
            grp_sym_mode[g] = q.grp[g].sym_mode;
            grp_stuff_adv4[g] = q.grp[g].stuff_adv4;
        end
    end

endmodule // imd_decoder

//--- design/imd_pkg.sv
// Purpose: Types of the command message decoder
// Assumes: imd_cfg.svh holds the numbers
// Notes:   Group count and buffer depth fixed here
package imd_pkg;

    // --------------------
    // Bus phase states
    // --------------------
    typedef enum logic [1:0] {
        IMD_BUS_IDLE = 2'b01,
        IMD_BUS_ACK  = 2'b10
    } imd_bus_t;

    // --------------------
    // Per-group configuration
    // --------------------
    typedef struct packed {
        logic [7:0]  logical_id;
        logic [1:0]  tx_m_code;
        logic [3:0]  rx_m_mask;
        logic [10:0] max_delay;
        logic        compat_v10;
        logic [2:0]  tx_min;
        logic [2:0]  rx_min;
        logic [4:0]  tx_port;
        logic [4:0]  rx_port;
        logic [1:0]  sym_mode;
        logic        stuff_common;
        logic        stuff_adv4;
        logic        configured;
    } imd_grp_t;

    // --------------------
    // Whole state of the decoder
    // --------------------
    typedef struct packed {
        imd_bus_t               bus_st;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic [15:0][7:0]       cmd_buf;
        logic [4:0]             cmd_len;
        logic [2:0][7:0]        out_buf;
        logic [1:0]             out_len;
        logic [1:0]             out_idx;
        logic [31:0]            tx_port_en;
        logic [31:0]            rx_port_en;
        logic [1:0]             loop_mode;
        logic [7:0]             lcd_thr;
        logic                   dev_setup_done;
        imd_grp_t [3:0]         grp;
        logic [1:0]             grp_sel;
        logic [3:0][7:0]        lcd_cnt;
        logic [3:0]             lcd_defect;
        logic [3:0]             alarm_pend;
        logic [3:0][10:0]       stuff_cnt;
        logic [3:0]             stuff_pulse;
        logic [3:0]             grp_oper;
        logic [3:0][8:0]        tx_frame_len;
    } imd_state_t;

endpackage

//--- testbench/ima_command_message_decoder_tb.sv
// Purpose: Self-checking bench of the command message decoder
// Assumes: Same-clock link inputs
// Notes:   Seed 28; alarm type value is arbitrary
`timescale 1ns/10ps
`include "imd_cfg.svh"

module ima_command_message_decoder_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, hd, h, k, v;
    logic [7:0] q[$];
    logic [31:0] pwdata, prdata, tx_port_en, rx_port_en, tm, r;
    logic [1:0] loop_mode;
    logic [3:0] cell_tick, ocd_anomaly, lcd_defect, stuff_insert;
    logic [3:0] grp_compat_v10, grp_stuff_adv4, grp_operational;
    logic [3:0][1:0] link_group, grp_sym_mode;
    logic [3:0][2:0] tx_link_cnt, rx_link_cnt;
    logic [3:0][3:0] grp_rx_m_mask;
    logic [3:0][4:0] grp_tx_port, grp_rx_port;
    logic [3:0][7:0] grp_logical_id;
    logic [3:0][8:0] grp_tx_frame_len;
    int fail_count, n_checks, i, g, s0, s1;

    imd_host u_host (.*);
    imd_decoder #(.ALARM_LCD(8'h2a)) u_dut (.*);

    task automatic chk(input string nm, input logic [31:0] x, y);
        n_checks++;
        if (y !== x) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, x, y);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [7:0] cap(input logic [7:0] x, input logic [7:0] m);
        return (x > m) ? 8'h00 : x;
    endfunction
    task automatic run(input logic [7:0] ack);
        hd = 8'($urandom_range(126));
        q.push_front(hd);
        u_host.cmd(q, h, k);
        chk("handler", hd + 8'h80, h);
        chk("ack", ack, k);
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #80000;
        fail_count++;
        test_done();
    end
    initial begin
        presetn = 1'b0;
        {cell_tick, ocd_anomaly, tx_link_cnt, rx_link_cnt} = '0;
        link_group = {2'h3, 2'h2, 2'h1, 2'h0};
        void'($urandom(28));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("tx_port_en", 32'h0, tx_port_en);
        chk("tx_port", 5'h1f, grp_tx_port[2]);
        chk("adv4", 4'hf, grp_stuff_adv4);
        chk("frame", 9'h020, grp_tx_frame_len[1]);
        tm = $urandom();
        r = $urandom();
        q = {8'h03};
        for (i = 7; i >= 0; i--) q.push_back(8'({tm, r} >> 8*i));
        run(8'h00);
        chk("tx_port_en", tm, tx_port_en);
        chk("rx_port_en", r, rx_port_en);
        q = {8'h03, 8'h11};
        run(8'h01);
        chk("tx_port_en", tm, tx_port_en);
        for (i = 0; i < 6; i++) begin
            v = (i == 5) ? 8'($urandom_range(255, 4)) : 8'(i);
            q = {8'h04, v};
            run(8'h00);
            chk("loop", cap(v, 8'h03), loop_mode);
        end
        q = {8'h06, 8'h02, 8'h05, 8'h06};
        run(8'h02);
        $display("test device done");
        for (g = 0; g < 4; g++) begin
            v = 8'($urandom());
            tm = $urandom();
            q = {8'h05, 8'(g), v, 8'(g), 8'(tm[3:0]), 8'h04, 8'h00};
            q = {q, 8'(g % 2), 8'(g + 1), 8'(4 - g)};
            run(8'h00);
            chk("logical id", v, grp_logical_id[g]);
            chk("frame", 9'h020 << g, grp_tx_frame_len[g]);
            chk("rx mask", tm[3:0], grp_rx_m_mask[g]);
            chk("compat", g % 2, grp_compat_v10[g]);
            v = {3'h7, 5'($urandom_range(30))};
            q = {8'h06, 8'(g), v, 8'h1e};
            run(8'h00);
            chk("tx port", v[4:0], grp_tx_port[g]);
            chk("rx port", 5'h1e, grp_rx_port[g]);
            v = (g == 3) ? 8'h07 : 8'(g);
            q = {8'h07, 8'(g), v, 8'(g == 0), (g % 2) ? 8'hfe : 8'h01};
            run(8'h00);
            chk("sym", cap(v, 8'h02), grp_sym_mode[g]);
            chk("adv4", g % 2 == 0, grp_stuff_adv4[g]);
        end
        {tx_link_cnt, rx_link_cnt} <= {2{12'h011}};
        repeat (3) @(posedge pclk);
        chk("oper", 4'h1, grp_operational);
        {tx_link_cnt, rx_link_cnt} <= {8{3'h4}};
        repeat (3) @(posedge pclk);
        chk("oper", 4'hf, grp_operational);
        $display("test groups done");
        q = {8'h01, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h05};
        run(8'h00);
        ocd_anomaly <= 4'h2;
        for (i = 0; i < 5; i++) begin
            cell_tick <= 4'h2;
            @(posedge pclk);
            cell_tick <= 4'h0;
            repeat (3) @(posedge pclk);
            chk("defect", (i == 4) ? 4'h2 : 4'h0, lcd_defect);
        end
        for (i = 0; i < 3; i++) begin
            u_host.xfer(1'b0, `IMD_REG_MSG_DATA, 32'h0, r, e);
            chk("alarm", (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'h2a, r[7:0]);
        end
        ocd_anomaly <= 4'h0;
        repeat (2) @(posedge pclk);
        chk("defect", 4'h0, lcd_defect);
        u_host.xfer(1'b0, 8'h40, 32'h0, r, e);
        chk("pslverr", 1'b1, e);
        $display("test defect done");
        {s0, s1} = '0;
        for (i = 0; i < 2060; i++) begin
            cell_tick <= (i < 2048) ? 4'hf : 4'h0;
            @(posedge pclk);
            s0 += int'(stuff_insert[0]);
            s1 += int'(|stuff_insert[3:1]);
        end
        chk("stuff common", 1, s0);
        chk("stuff indep", 0, s1);
        $display("test stuff done");
        test_done();
    end
endmodule // ima_command_message_decoder_tb

//--- testbench/imd_decoder_sva.sv
// Purpose: Port checks of the command message decoder
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound into every decoder instance
`timescale 1ns/10ps
`include "imd_cfg.svh"

module imd_decoder_sva (
    // Clock, reset, bus
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic            pready,
    // Links and outputs
    input wire logic [3:0]      cell_tick,
    input wire logic [3:0]      ocd_anomaly,
    input wire logic [3:0][2:0] tx_link_cnt,
    input wire logic [3:0][2:0] rx_link_cnt,
    input wire logic [1:0]      loop_mode,
    input wire logic [3:0]      lcd_defect,
    input wire logic [3:0]      stuff_insert,
    input wire logic [3:0][8:0] grp_tx_frame_len,
    input wire logic [3:0][1:0] grp_sym_mode,
    input wire logic [3:0]      grp_operational
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire exec_wr = psel & penable & pwrite & (paddr == `IMD_REG_MSG_CTRL);
    function automatic logic m_ok(input logic [8:0] f);
        return $onehot(f) && f >= `IMD_M_BASE;
    endfunction

    property p_ready_pulse; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready not one cycle");
    property p_loop_cause;
        $changed(loop_mode) |-> $past(exec_wr) || $past(exec_wr, 2) || $past(exec_wr, 3);
    endproperty
    a_loop_cause: assert property (p_loop_cause) else $error("loop moved alone");
    property p_lcd_cause; (lcd_defect & ~$past(ocd_anomaly)) == 4'h0; endproperty
    a_lcd_cause: assert property (p_lcd_cause) else $error("defect, no anomaly");
    property p_stuff_cause;
        (stuff_insert & ~($past(cell_tick) | $past(cell_tick, 2))) == 4'h0;
    endproperty
    a_stuff_cause: assert property (p_stuff_cause) else $error("stuff, no tick");
    property p_frame_legal;
        m_ok(grp_tx_frame_len[0]) && m_ok(grp_tx_frame_len[1])
            && m_ok(grp_tx_frame_len[2]) && m_ok(grp_tx_frame_len[3]);
    endproperty
    a_frame_legal: assert property (p_frame_legal) else $error("bad frame len");
    property p_sym_legal;
        !(&grp_sym_mode[0] || &grp_sym_mode[1] || &grp_sym_mode[2] || &grp_sym_mode[3]);
    endproperty
    a_sym_legal: assert property (p_sym_legal) else $error("sym mode 3");
    property p_oper_tx; grp_operational[0] |-> $past(tx_link_cnt[0]) != 3'h0; endproperty
    a_oper_tx: assert property (p_oper_tx) else $error("oper, no tx");
    property p_oper_rx; $rose(grp_operational[1]) |-> $past(rx_link_cnt[1]) != 3'h0; endproperty
    a_oper_rx: assert property (p_oper_rx) else $error("oper, no rx");
endmodule // imd_decoder_sva

bind imd_decoder imd_decoder_sva u_sva (.*);

//--- testbench/imd_host.sv
// Purpose: Host processor model issuing command messages over APB
// Assumes: Waits for pready, however late
// Notes:   Bus idles one cycle between transfers
`timescale 1ns/10ps
`include "imd_cfg.svh"

module imd_host (
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data toggles so no one leans on stale values
        pwdata <= ~d;
        @(posedge pclk);
    endtask

    // Only listed codes are ever sent, handler first
    task automatic cmd(input logic [7:0] q[$], output logic [7:0] h, k);
        logic [31:0] r;
        logic        e;
        foreach (q[i]) xfer(1'b1, `IMD_REG_MSG_DATA, {24'h0, q[i]}, r, e);
        xfer(1'b1, `IMD_REG_MSG_CTRL, 32'h1, r, e);
        xfer(1'b0, `IMD_REG_MSG_DATA, 32'h0, r, e);
        h = r[7:0];
        xfer(1'b0, `IMD_REG_MSG_DATA, 32'h0, r, e);
        k = r[7:0];
    endtask
endmodule // imd_host
